// >>> logic/cicr_pkg.sv
/*
 cicr_pkg: offsets, bit positions, reset values and carrier types of the
 core interrupt control register block.
 Assumes a 9-bit data address space with four register banks.
*/
`default_nettype none

package cicr_pkg;

   // data address width seen by the register port
   localparam int ADDR_W = 9;

   // interrupt_control mirrored once per bank
   localparam logic [8:0] CTRL_ADDR_BANK0 = 9'h00B;
   localparam logic [8:0] CTRL_ADDR_BANK1 = 9'h08B;
   localparam logic [8:0] CTRL_ADDR_BANK2 = 9'h10B;
   localparam logic [8:0] CTRL_ADDR_BANK3 = 9'h18B;

   // event status (write one to clear) and its mask
   localparam logic [8:0] EVT_STATUS_ADDR = 9'h1F0;
   localparam logic [8:0] EVT_MASK_ADDR   = 9'h1F1;

   // interrupt_control field positions
   localparam int GLOBAL_EN_BIT  = 7;
   localparam int PERIPH_EN_BIT  = 6;
   localparam int TIMER_EN_BIT   = 5;
   localparam int EXT_EN_BIT     = 4;
   localparam int PCHG_EN_BIT    = 3;
   localparam int TIMER_FLAG_BIT = 2;
   localparam int EXT_FLAG_BIT   = 1;
   localparam int PCHG_FLAG_BIT  = 0;

   // event status / mask field positions
   localparam int EVT_PCHG_BIT   = 0;
   localparam int EVT_EXT_BIT    = 1;
   localparam int EVT_TIMER_BIT  = 2;
   localparam int EVT_PERIPH_BIT = 3;
   localparam int EVT_W          = 4;

   // values after reset
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [3:0] EVT_RESET    = 4'h0;
   localparam logic [3:0] MASK_RESET   = 4'h0;
   localparam logic [3:0] PINS_RESET   = 4'h0;
   localparam logic [7:0] RDDATA_RESET = 8'h00;

   // synchroniser depth and pin count
   localparam int SYNC_STAGES = 3;
   localparam int PIN_COUNT   = 4;

   // register port request
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wrData;
      logic       wrStrobe;
      logic       rdStrobe;
   } cicr_bus_req_t;

   // whole state of the block
   typedef struct packed {
      logic [7:0]                  ctrl;
      logic [3:0]                  evtStatus;
      logic [3:0]                  evtMask;
      logic [7:0]                  rdData;
      logic [2:0]                  extSync;
      logic [2:0][3:0]             pinSync;
      logic                        extStable;
      logic [3:0]                  pinStable;
      logic [3:0]                  pinLatched;
   } cicr_state_t;

endpackage : cicr_pkg

`default_nettype wire

// >>> logic/cicr_interrupt_control.sv
/*
 cicr_interrupt_control: the core interrupt control register, its flags,
 the upper-port pin-change detector, the external pin edge detector, an
 event status/mask pair and the core interrupt request.
 Assumes one clock (ref_clk, 25 MHz), synchronous active-high reset, a
 register port with read data one cycle after the read strobe, and that
 timer, peripheral and core strobes come from logic on the same clock.
 Limitations: the external pin flag takes rising edges only, and the
 peripheral sources keep their own flags outside this block.
*/
`timescale 1ns/1ns
`default_nettype none

module cicr_interrupt_control
(
   input  wire logic                    ref_clk,
   input  wire logic                    sys_rst,
   input  wire cicr_pkg::cicr_bus_req_t busReq,
   output logic [7:0]                   rdData,
   input  wire logic                    timerOverflow,
   input  wire logic                    extIrqPin,
   input  wire logic [3:0]              upperPortPins,
   input  wire logic                    portRead,
   output logic [3:0]                   upperPinsLatched,
   input  wire logic                    peripheralIrq,
   input  wire logic                    irqEntry,
   input  wire logic                    returnFromIrq,
   output logic                         coreIrqReq,
   output logic                         irqOut
);

   cicr_pkg::cicr_state_t s;
   cicr_pkg::cicr_state_t next_s;

   logic                  extRise;
   logic                  pinMismatch;
   logic [3:0]            events;

   // per-source request terms
   logic                  timerReq;
   logic                  extReq;
   logic                  pinReq;
   logic                  periphReq;

   // any of the four bank mirrors selects the same register
   function automatic logic isCtrlAddr(input logic [8:0] a);
      isCtrlAddr = (a == cicr_pkg::CTRL_ADDR_BANK0) || (a == cicr_pkg::CTRL_ADDR_BANK1) ||
                   (a == cicr_pkg::CTRL_ADDR_BANK2) || (a == cicr_pkg::CTRL_ADDR_BANK3);
   endfunction : isCtrlAddr

   // event status sits at one address; decoded for write and read
   function automatic logic isStatusAddr(input logic [8:0] a);
      isStatusAddr = (a == cicr_pkg::EVT_STATUS_ADDR);
   endfunction : isStatusAddr

   // mask register, likewise decoded for write and read
   function automatic logic isMaskAddr(input logic [8:0] a);
      isMaskAddr = (a == cicr_pkg::EVT_MASK_ADDR);
   endfunction : isMaskAddr

   // rising edge only once the second and third stages agree; a
   // single-clock glitch never reaches the filtered level
   assign extRise = (s.extSync[1] == s.extSync[2]) && s.extSync[2] && !s.extStable;

   // mismatch of the filtered pins against the last-read latch, or'ed
   assign pinMismatch = |(s.pinStable ^ s.pinLatched);

   // event strobes feeding the sticky status register
   // peripheral input is a level, so its status bit re-sets while held
   always_comb
   begin
      events                           = '0;
      events[cicr_pkg::EVT_PCHG_BIT]   = pinMismatch;
      events[cicr_pkg::EVT_EXT_BIT]    = extRise;
      events[cicr_pkg::EVT_TIMER_BIT]  = timerOverflow;
      events[cicr_pkg::EVT_PERIPH_BIT] = peripheralIrq;
   end

   // next state of the whole block
   always_comb
   begin
      next_s = s;

      // synchronisers: stage 0 feeds only stage 1; a filtered bit moves
      // only when stages 1 and 2 agree, so a metastable value never counts
      next_s.extSync = {s.extSync[1:0], extIrqPin};
      next_s.pinSync = {s.pinSync[1:0], upperPortPins};
      if (s.extSync[1] == s.extSync[2])
      begin
         next_s.extStable = s.extSync[2];
      end
      for (int i = 0; i < cicr_pkg::PIN_COUNT; i++)
      begin
         if (s.pinSync[1][i] == s.pinSync[2][i])
         begin
            next_s.pinStable[i] = s.pinSync[2][i];
         end
      end

      // a port read re-arms the comparison and ends the mismatch; a pin
      // that moves while the read is taken still differs from the latch
      // afterwards, so its flag is set a cycle later instead of lost
      if (portRead)
      begin
         next_s.pinLatched = s.pinStable;
      end

      // software write to the mirrored register
      if (busReq.wrStrobe && isCtrlAddr(busReq.addr))
      begin
         next_s.ctrl = busReq.wrData;
      end

      // core entry clears global enable; return sets it again and wins,
      // so an entry racing a software clear of the global enable can be
      // undone by the return: that hazard is left to software
      if (irqEntry)
      begin
         next_s.ctrl[cicr_pkg::GLOBAL_EN_BIT] = 1'b0;
      end
      if (returnFromIrq)
      begin
         next_s.ctrl[cicr_pkg::GLOBAL_EN_BIT] = 1'b1;
      end

      // flags set after the write so an event beats a clear
      if (timerOverflow)
      begin
         next_s.ctrl[cicr_pkg::TIMER_FLAG_BIT] = 1'b1;
      end
      if (extRise)
      begin
         next_s.ctrl[cicr_pkg::EXT_FLAG_BIT] = 1'b1;
      end
      if (pinMismatch)
      begin
         next_s.ctrl[cicr_pkg::PCHG_FLAG_BIT] = 1'b1;
      end

      // sticky status: write one clears, a same-cycle event wins
      if (busReq.wrStrobe && isStatusAddr(busReq.addr))
      begin
         next_s.evtStatus = s.evtStatus & ~busReq.wrData[3:0];
      end
      next_s.evtStatus = next_s.evtStatus | events;

      if (busReq.wrStrobe && isMaskAddr(busReq.addr))
      begin
         next_s.evtMask = busReq.wrData[3:0];
      end

      // read data stands one cycle only; unmapped reads give zero
      // the bus never waits, so every read is answered the next cycle
      next_s.rdData = cicr_pkg::RDDATA_RESET;
      if (busReq.rdStrobe)
      begin
         if (isCtrlAddr(busReq.addr))
         begin
            next_s.rdData = s.ctrl;
         end
         else if (isStatusAddr(busReq.addr))
         begin
            next_s.rdData = {4'h0, s.evtStatus};
         end
         else if (isMaskAddr(busReq.addr))
         begin
            next_s.rdData = {4'h0, s.evtMask};
         end
      end
   end

   // single state register; reset loads constants only
   // (the reset branch never reads state, so no unknown survives it)
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s            <= '0;
         s.ctrl       <= cicr_pkg::CTRL_RESET;
         s.evtStatus  <= cicr_pkg::EVT_RESET;
         s.evtMask    <= cicr_pkg::MASK_RESET;
         s.rdData     <= cicr_pkg::RDDATA_RESET;
         s.pinStable  <= cicr_pkg::PINS_RESET;
         s.pinLatched <= cicr_pkg::PINS_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // each source pairs its flag with its own enable bit
   assign timerReq  = s.ctrl[cicr_pkg::TIMER_EN_BIT] && s.ctrl[cicr_pkg::TIMER_FLAG_BIT];
   assign extReq    = s.ctrl[cicr_pkg::EXT_EN_BIT] && s.ctrl[cicr_pkg::EXT_FLAG_BIT];
   assign pinReq    = s.ctrl[cicr_pkg::PCHG_EN_BIT] && s.ctrl[cicr_pkg::PCHG_FLAG_BIT];

   // peripheral flags live in their own blocks; only the group enable is here
   assign periphReq = s.ctrl[cicr_pkg::PERIPH_EN_BIT] && peripheralIrq;

   // global enable gates every source; a flag left set before its enable
   // is raised requests at once, which is why software clears it first
   assign coreIrqReq = s.ctrl[cicr_pkg::GLOBAL_EN_BIT] &&
                       (timerReq || extReq || pinReq || periphReq);

   // level interrupt while any unmasked status bit is set
   assign irqOut           = |(s.evtStatus & s.evtMask);
   assign rdData           = s.rdData;
   assign upperPinsLatched = s.pinLatched;

endmodule : cicr_interrupt_control

`default_nettype wire

// >>> tb/cicr_core_model.sv
/*
 cicr_core_model: processor core side of the core interrupt request.
 Assumes the request is a level on ref_clk and the bench commands returns.
*/
`timescale 1ns/1ns
`default_nettype none
module cicr_core_model
(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic coreIrqReq,
   input  wire logic retCmd,
   output logic      irqEntry,
   output logic      returnFromIrq
);
   // one entry per request; the global enable clear then drops it
   always_ff @(posedge ref_clk)
   begin
      irqEntry      <= !sys_rst && coreIrqReq && !irqEntry;
      returnFromIrq <= !sys_rst && retCmd;
   end
endmodule : cicr_core_model
`default_nettype wire

// >>> tb/cicr_interrupt_control_sva.sv
/*
 cicr_interrupt_control_sva: timing relations at the block ports.
 Assumes one clock and that read data show the register one cycle late.
*/
`timescale 1ns/1ns
`default_nettype none
module cicr_interrupt_control_sva
(
   input wire logic                    ref_clk,
   input wire logic                    sys_rst,
   input wire cicr_pkg::cicr_bus_req_t busReq,
   input wire logic [7:0]              rdData,
   input wire logic                    timerOverflow,
   input wire logic [3:0]              upperPortPins,
   input wire logic                    portRead,
   input wire logic [3:0]              upperPinsLatched,
   input wire logic                    irqEntry,
   input wire logic                    returnFromIrq,
   input wire logic                    coreIrqReq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   logic ctrlRd;
   logic ctrlPrev;
   logic anyRd;
   logic reqPrev;
   // all four bank mirrors share the low seven address bits
   assign ctrlRd = busReq.rdStrobe && busReq.addr[6:0] == 7'h0B;
   // history so read data can be tied to the cycle they show
   always_ff @(posedge ref_clk)
   begin
      ctrlPrev <= ctrlRd;
      anyRd    <= busReq.rdStrobe;
      reqPrev  <= coreIrqReq;
   end
   a_timer_flag: assert property (timerOverflow ##1 ctrlRd |=> rdData[2])
      else $error("timer flag not set");
   a_rd_idle: assert property (!anyRd |-> rdData == 8'h00)
      else $error("read data outside read slot");
   a_gie_gate: assert property (ctrlPrev && !rdData[7] |-> !reqPrev)
      else $error("request with global enable off");
   a_entry_clear: assert property (irqEntry && !returnFromIrq && !busReq.wrStrobe |=> !coreIrqReq)
      else $error("request after entry");
   a_req_on: assert property (ctrlPrev && rdData[7] && rdData[5] && rdData[2] |-> reqPrev)
      else $error("missing request");
   a_return_gie: assert property (returnFromIrq ##1 ctrlRd |=> rdData[7])
      else $error("return did not set global enable");
   a_latch_hold: assert property (!portRead |=> $stable(upperPinsLatched))
      else $error("latch moved without port read");
   a_pin_flag: assert property ((upperPortPins != upperPinsLatched && $stable(upperPortPins) && !portRead) [*7]
      ##0 ctrlRd |=> rdData[0])
      else $error("pin flag not set on mismatch");
   c_timer: cover property (timerOverflow);
   c_req: cover property ($rose(coreIrqReq));
   c_read: cover property (portRead);
endmodule : cicr_interrupt_control_sva
bind cicr_interrupt_control cicr_interrupt_control_sva sva
(
   .ref_clk          (ref_clk),
   .sys_rst          (sys_rst),
   .busReq           (busReq),
   .rdData           (rdData),
   .timerOverflow    (timerOverflow),
   .upperPortPins    (upperPortPins),
   .portRead         (portRead),
   .upperPinsLatched (upperPinsLatched),
   .irqEntry         (irqEntry),
   .returnFromIrq    (returnFromIrq),
   .coreIrqReq       (coreIrqReq)
);
`default_nettype wire

// >>> tb/cicr_interrupt_control_tb_top.sv
/*
 cicr_interrupt_control_tb_top: register, event and core request tests.
 Assumes the design and the core model on one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cicr_interrupt_control_tb_top;
   logic                    ref_clk;
   logic                    sys_rst;
   logic                    timerOverflow;
   logic                    extIrqPin;
   logic                    peripheralIrq;
   logic                    portRead;
   logic                    retCmd;
   logic                    irqEntry;
   logic                    returnFromIrq;
   logic                    coreIrqReq;
   logic                    irqOut;
   logic [7:0]              rdData;
   logic [3:0]              upperPortPins;
   logic [3:0]              upperPinsLatched;
   cicr_pkg::cicr_bus_req_t busReq;
   int                      num_errors;
   int                      checked;
   int                      i;
   // every design input but irqEntry and returnFromIrq comes from the bench, which drives each source; those two come from the core model
   cicr_interrupt_control uut
   (
      .ref_clk          (ref_clk),
      .sys_rst          (sys_rst),
      .busReq           (busReq),
      .rdData           (rdData),
      .timerOverflow    (timerOverflow),
      .extIrqPin        (extIrqPin),
      .upperPortPins    (upperPortPins),
      .portRead         (portRead),
      .upperPinsLatched (upperPinsLatched),
      .peripheralIrq    (peripheralIrq),
      .irqEntry         (irqEntry),
      .returnFromIrq    (returnFromIrq),
      .coreIrqReq       (coreIrqReq),
      .irqOut           (irqOut)
   );
   cicr_core_model core
   (
      .ref_clk       (ref_clk),
      .sys_rst       (sys_rst),
      .coreIrqReq    (coreIrqReq),
      .retCmd        (retCmd),
      .irqEntry      (irqEntry),
      .returnFromIrq (returnFromIrq)
   );
   // clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk) busReq <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) busReq.wrStrobe <= 1'b0;
   endtask : wr
   // also ends any timer pulse, so a read may follow it at once
   task rd(input logic [8:0] a, input logic [7:0] e);
      @(posedge ref_clk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
      timerOverflow <= 1'b0;
      @(posedge ref_clk) busReq.rdStrobe <= 1'b0;
      #1 chk(rdData, e);
   endtask : rd
   // bounded wait for the core entry to drop the request; looks 1 ns
   // after each edge so the design's update is already visible
   task wait_req_low;
      for (i = 0; i < 8 && coreIrqReq !== 1'b0; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask : wait_req_low
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // main sequence; a hung wait leaves the tests and goes to the verdict
   initial
   begin
      sys_rst = 1'b1;
      busReq = '0;
      timerOverflow = 1'b0;
      portRead = 1'b0;
      retCmd = 1'b0;
      extIrqPin = 1'b0;
      peripheralIrq = 1'b0;
      upperPortPins = 4'h0;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      begin : tests
         for (i = 0; i < 4; i++)
            rd({i[1:0], 7'h0B}, 8'h00);
         rd(9'h1F1, 8'h00);
         wr(9'h10B, 8'h38);
         rd(9'h18B, 8'h38);
         $display("test registers done");
         @(posedge ref_clk) timerOverflow <= 1'b1;
         rd(9'h08B, 8'h3C);
         chk({7'h00, coreIrqReq}, 8'h00);
         @(posedge ref_clk) retCmd <= 1'b1;
         @(posedge ref_clk) retCmd <= 1'b0;
         rd(9'h00B, 8'hBC);
         chk({7'h00, coreIrqReq}, 8'h01);
         wait_req_low();
         if (coreIrqReq !== 1'b0)
         begin
            num_errors++;
            disable tests;
         end
         rd(9'h00B, 8'h3C);
         wr(9'h1F1, 8'h04);
         #1 chk({7'h00, irqOut}, 8'h01);
         wr(9'h1F0, 8'h04);
         #1 chk({7'h00, irqOut}, 8'h00);
         $display("test events done");
         @(posedge ref_clk) upperPortPins <= 4'hA;
         wr(9'h00B, 8'h08);
         repeat (7) @(posedge ref_clk);
         rd(9'h00B, 8'h09);
         wr(9'h00B, 8'h08);
         rd(9'h00B, 8'h09);
         @(posedge ref_clk) portRead <= 1'b1;
         @(posedge ref_clk) portRead <= 1'b0;
         #1 chk({4'h0, upperPinsLatched}, 8'h0A);
         wr(9'h00B, 8'h08);
         rd(9'h00B, 8'h08);
         rd(9'h1F2, 8'h00);
         $display("test pins done");
         // external pin: flag on the filtered rising edge, not on the level
         wr(9'h00B, 8'h10);
         @(posedge ref_clk) extIrqPin <= 1'b1;
         repeat (6) @(posedge ref_clk);
         rd(9'h00B, 8'h12);
         wr(9'h00B, 8'h10);
         rd(9'h00B, 8'h10);
         rd(9'h1F0, 8'h03);
         wr(9'h1F0, 8'h0F);
         rd(9'h1F0, 8'h00);
         @(posedge ref_clk) extIrqPin <= 1'b0;
         $display("test external pin done");
         // peripheral level: needs group enable and global enable
         wr(9'h00B, 8'h40);
         @(posedge ref_clk) peripheralIrq <= 1'b1;
         #1 chk({7'h00, coreIrqReq}, 8'h00);
         wr(9'h00B, 8'hC0);
         #1 chk({7'h00, coreIrqReq}, 8'h01);
         wait_req_low();
         if (coreIrqReq !== 1'b0)
         begin
            num_errors++;
            disable tests;
         end
         rd(9'h00B, 8'h40);
         wr(9'h00B, 8'h80);
         #1 chk({7'h00, coreIrqReq}, 8'h00);
         rd(9'h1F0, 8'h08);
         wr(9'h1F1, 8'h08);
         #1 chk({7'h00, irqOut}, 8'h01);
         @(posedge ref_clk) peripheralIrq <= 1'b0;
         wr(9'h1F0, 8'h08);
         #1 chk({7'h00, irqOut}, 8'h00);
         wr(9'h00B, 8'h00);
         $display("test peripheral done");
      end
      tally_and_finish();
   end
endmodule : cicr_interrupt_control_tb_top
`default_nettype wire
